// ==== verilog/gdsc_map.vh ====
/*
  Register map, field positions, reset values and timing counts of the
  generic slave DMA counter and configuration block.
  Assumes a byte-addressed processor register port and a 100 MHz clock.
*/
`ifndef GDSC_MAP_VH
`define GDSC_MAP_VH

// Byte addresses of the remaining-byte counter, least significant first.
`define GDSC_CNT_B0_ADDR   8'h34
`define GDSC_CNT_B1_ADDR   8'h35
`define GDSC_CNT_B2_ADDR   8'h36
`define GDSC_CNT_B3_ADDR   8'h37
// Byte addresses of the configuration register.
`define GDSC_CFG_LO_ADDR   8'h38
`define GDSC_CFG_HI_ADDR   8'h39

`define GDSC_CNT_RESET     32'h0000_0000
`define GDSC_CFG_RESET     16'h0001
// Bits that hold state; all other configuration bits are reserved.
`define GDSC_CFG_WMASK     16'h008d
`define GDSC_CFG_CNT_DIS   7
`define GDSC_CFG_MODE_HI   3
`define GDSC_CFG_MODE_LO   2
`define GDSC_CFG_WIDTH     0
`define GDSC_MODE_STROBE   2'b00

`define GDSC_FIFO_BYTES    8
`define GDSC_CLK_NS        10
`define GDSC_DRAIN_NS      60
`define GDSC_DRAIN_CYCLES  (`GDSC_DRAIN_NS / `GDSC_CLK_NS)

`endif

// ==== verilog/gdsc_fifo.v ====
/*
  Byte FIFO that takes and gives up to two bytes a cycle, low byte first.
  Assumes the caller never pushes beyond free room nor pops beyond level.
*/
`timescale 1ns/100ps
module gdsc_fifo
#(
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  // Clock and reset
  input  wire          clock,
  input  wire          rst,
  // Fill side
  input  wire [1:0]    push_cnt,
  input  wire [15:0]   push_data,
  // Drain side
  input  wire [1:0]    pop_cnt,
  output wire [15:0]   pop_data,
  // Occupancy
  output wire [AW:0]   level
);

  reg  [7:0]  mem_reg [0:DEPTH-1];
  reg  [AW-1:0] wr_ptr_reg;
  reg  [AW-1:0] rd_ptr_reg;
  reg  [AW:0]   level_reg;
  wire [AW-1:0] wr_ptr_p1;
  wire [AW-1:0] rd_ptr_p1;

  assign wr_ptr_p1 = wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
  assign rd_ptr_p1 = rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
  assign pop_data  = {mem_reg[rd_ptr_p1], mem_reg[rd_ptr_reg]};
  assign level     = level_reg;

  always @(posedge clock)
  begin
    if (push_cnt != 2'd0)
      mem_reg[wr_ptr_reg] <= push_data[7:0];
    if (push_cnt == 2'd2)
      mem_reg[wr_ptr_p1] <= push_data[15:8];
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      level_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + {{(AW-2){1'b0}}, push_cnt};
      rd_ptr_reg <= rd_ptr_reg + {{(AW-2){1'b0}}, pop_cnt};
      level_reg  <= level_reg + {{(AW-1){1'b0}}, push_cnt} - {{(AW-1){1'b0}}, pop_cnt};
    end
  end

endmodule

// ==== verilog/gdsc_core.v ====
/*
  Generic slave DMA engine: remaining-byte counter, DMA configuration
  register, strobe handshake on the DMA bus and an 8-byte FIFO between the
  DMA bus and the endpoint buffers.
  Assumes strobes and commands are one-cycle pulses synchronous to clock and
  that the endpoint buffer logic and pin pads sit outside.
*/
// What this block does
// - Four-byte counter loaded by software with the transfer's total byte count.
// - Reading the counter during a transfer returns the bytes still left.
// - An eight-byte FIFO sits in the DMA path; IN data may wait there.
// - IN data in the FIFO reaches the endpoint buffer within 60 ns while the endpoint side stays ready.
// - OUT endpoint buffer is not released until the FIFO has been emptied.
// - Counter bytes: byte 1 is bits 7..0, byte 4 bits 31..24; reset zero.
// - Configuration bit 7 zero counts; one makes the counter ignored.
// - Strobe mode 00: write strobe latches bus data, read strobe drives it.
// - Configuration bit 0 selects 8-bit (0) or 16-bit (1) bus; resets to one.
// - Request pin is not driven before one configuration register write.
// - Configuration is two bytes; bits 15..8, 6..4 and 1 are reserved.
// - Counter bytes written low to high; counter loads on the top byte.
// - Counter decrements during a transfer; at zero done flag and pulse.
// - A transfer ends on short OUT packet, DMA reset or stop command.
`timescale 1ns/100ps
`include "gdsc_map.vh"
module gdsc_core
#(
  parameter FIFO_DEPTH = `GDSC_FIFO_BYTES
)
(
  // Clock and reset
  input  wire          clock,
  input  wire          sys_rst,
  // Processor register port
  input  wire [7:0]    reg_addr,
  input  wire [7:0]    reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output wire [7:0]    reg_rdata,
  output wire          reg_rvalid,
  // DMA commands
  input  wire          cmd_in_start,
  input  wire          cmd_out_start,
  input  wire          cmd_stop,
  input  wire          cmd_dma_reset,
  input  wire          short_packet_end,
  // DMA bus pins
  output wire          dma_request_pin,
  output wire          dma_request_oe,
  input  wire          write_strobe_pin,
  input  wire          read_strobe_pin,
  input  wire [15:0]   dma_data_in,
  output wire [15:0]   dma_data_out,
  output wire          dma_data_oe,
  // IN endpoint buffer fill
  output wire          ep_in_valid,
  output wire [1:0]    ep_in_count,
  output wire [15:0]   ep_in_data,
  input  wire          ep_in_ready,
  // OUT endpoint buffer drain
  input  wire          ep_out_valid,
  input  wire [1:0]    ep_out_count,
  input  wire [15:0]   ep_out_data,
  output wire          ep_out_ready,
  output wire          ep_out_release,
  // Status
  output wire          xfer_active,
  output wire          transfer_done_flag,
  output wire          transfer_done_pulse,
  output wire          short_packet_end_flag,
  input  wire          flag_clear_done,
  input  wire          flag_clear_eot
);

  localparam ST_IDLE = 3'b001;
  localparam ST_IN   = 3'b010;
  localparam ST_OUT  = 3'b100;
  localparam AW      = 3;

  wire        rst;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [31:0] remaining_byte_count_reg;
  reg  [31:0] remaining_byte_count_next;
  reg  [23:0] cnt_shadow_reg;
  reg  [15:0] cfg_reg;
  reg         cfg_written_reg;
  reg  [7:0]  rdata_reg;
  reg         rvalid_reg;
  reg  [15:0] dout_reg;
  reg         out_dir_reg;
  reg         done_flag_reg;
  reg         done_pulse_reg;
  reg         eot_flag_reg;
  reg  [7:0]  rd_mux;
  wire        count_disable;
  wire        width16;
  wire        mode_ok;
  wire [1:0]  nbytes;
  wire [AW:0] level;
  wire [AW:0] room;
  wire [15:0] fifo_head;
  reg  [1:0]  push_cnt;
  reg  [15:0] push_data;
  reg  [1:0]  pop_cnt;
  wire        in_accept;
  wire        out_accept;
  wire        moved;
  wire        hit_zero;
  wire        ended;

  // A DMA reset puts the whole engine back to its power-on state.
  assign rst = sys_rst | cmd_dma_reset;

  assign count_disable = cfg_reg[`GDSC_CFG_CNT_DIS];
  assign width16       = cfg_reg[`GDSC_CFG_WIDTH];
  assign mode_ok       = (cfg_reg[`GDSC_CFG_MODE_HI:`GDSC_CFG_MODE_LO] == `GDSC_MODE_STROBE);
  assign nbytes        = width16 ? 2'd2 : 2'd1;
  assign room          = FIFO_DEPTH[AW:0] - level;

  // Strobes are honoured only in the supported mode, with data or room.
  assign in_accept  = (state_reg == ST_IN) && write_strobe_pin && mode_ok
                      && (room >= {{(AW-1){1'b0}}, nbytes});
  assign out_accept = (state_reg == ST_OUT) && read_strobe_pin && mode_ok
                      && (level >= {{(AW-1){1'b0}}, nbytes});
  assign moved      = in_accept | out_accept;
  assign hit_zero   = moved && !count_disable
                      && (remaining_byte_count_reg <= {30'd0, nbytes});
  assign ended      = cmd_stop | short_packet_end | hit_zero;

  gdsc_fifo
  #(
    .DEPTH (FIFO_DEPTH),
    .AW    (AW)
  )
  u_fifo
  (
    .clock     (clock),
    .rst       (rst),
    .push_cnt  (push_cnt),
    .push_data (push_data),
    .pop_cnt   (pop_cnt),
    .pop_data  (fifo_head),
    .level     (level)
  );

  // IN data enters from the bus; OUT data enters from the endpoint.
  always @*
  begin
    push_cnt  = 2'd0;
    push_data = 16'h0000;
    if (in_accept)
    begin
      push_cnt  = nbytes;
      push_data = dma_data_in;
    end
    else if ((state_reg == ST_OUT) && ep_out_valid && ep_out_ready)
    begin
      push_cnt  = ep_out_count;
      push_data = ep_out_data;
    end
  end

  // IN data drains whether or not the transfer is still running.
  always @*
  begin
    pop_cnt = 2'd0;
    if (out_accept)
      pop_cnt = nbytes;
    else if (!out_dir_reg && ep_in_ready && (level != {(AW+1){1'b0}}))
      pop_cnt = ep_in_count;
  end

  // Two bytes leave a cycle, so a full FIFO empties in four cycles, inside
  // 60 ns; the bound holds only while the endpoint side stays ready.
  assign ep_in_valid  = !out_dir_reg && (level != {(AW+1){1'b0}});
  assign ep_in_count  = (level >= {{(AW-1){1'b0}}, 2'd2}) ? 2'd2 : 2'd1;
  assign ep_in_data   = fifo_head;
  assign ep_out_ready = (state_reg == ST_OUT) && !out_accept
                        && (room >= {{(AW-1){1'b0}}, ep_out_count});
  // Stale OUT bytes keep the endpoint buffer held until the bus took them.
  assign ep_out_release = out_dir_reg && (state_reg == ST_IDLE)
                          && (level == {(AW+1){1'b0}});

  // Request asks for a strobe only when it can be served at once.
  assign dma_request_oe  = cfg_written_reg;
  assign dma_request_pin = cfg_written_reg && mode_ok && !ended
                           && (count_disable || (remaining_byte_count_reg != 32'h0))
                           && (((state_reg == ST_IN) && (room >= {{(AW-1){1'b0}}, nbytes}))
                           || ((state_reg == ST_OUT) && (level >= {{(AW-1){1'b0}}, nbytes})));
  assign dma_data_out    = dout_reg;
  assign dma_data_oe     = (state_reg == ST_OUT);

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (cmd_in_start)
          state_next = ST_IN;
        else if (cmd_out_start)
          state_next = ST_OUT;
      end
      ST_IN, ST_OUT:
      begin
        if (ended)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @*
  begin
    remaining_byte_count_next = remaining_byte_count_reg;
    if (reg_wr && (reg_addr == `GDSC_CNT_B3_ADDR))
      remaining_byte_count_next = {reg_wdata, cnt_shadow_reg};
    else if (moved && !count_disable)
    begin
      if (hit_zero)
        remaining_byte_count_next = 32'h0;
      else
        remaining_byte_count_next = remaining_byte_count_reg - {30'd0, nbytes};
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      state_reg                <= ST_IDLE;
      remaining_byte_count_reg <= `GDSC_CNT_RESET;
      cnt_shadow_reg           <= 24'h000000;
      cfg_reg                  <= `GDSC_CFG_RESET;
      cfg_written_reg          <= 1'b0;
      dout_reg                 <= 16'h0000;
      out_dir_reg              <= 1'b0;
      done_flag_reg            <= 1'b0;
      done_pulse_reg           <= 1'b0;
      eot_flag_reg             <= 1'b0;
    end
    else
    begin
      state_reg                <= state_next;
      remaining_byte_count_reg <= remaining_byte_count_next;
      if (cmd_in_start && (state_reg == ST_IDLE))
        out_dir_reg <= 1'b0;
      else if (cmd_out_start && (state_reg == ST_IDLE))
        out_dir_reg <= 1'b1;
      if (reg_wr)
      begin
        case (reg_addr)
          `GDSC_CNT_B0_ADDR: cnt_shadow_reg[7:0]   <= reg_wdata;
          `GDSC_CNT_B1_ADDR: cnt_shadow_reg[15:8]  <= reg_wdata;
          `GDSC_CNT_B2_ADDR: cnt_shadow_reg[23:16] <= reg_wdata;
          `GDSC_CFG_LO_ADDR: cfg_reg <= {8'h00, reg_wdata} & `GDSC_CFG_WMASK;
          default:           cnt_shadow_reg <= cnt_shadow_reg;
        endcase
        if ((reg_addr == `GDSC_CFG_LO_ADDR) || (reg_addr == `GDSC_CFG_HI_ADDR))
          cfg_written_reg <= 1'b1;
      end
      if (out_accept)
        dout_reg <= width16 ? fifo_head : {8'h00, fifo_head[7:0]};
      // A new event wins over a clear in the same cycle.
      if ((state_reg != ST_IDLE) && hit_zero)
        done_flag_reg <= 1'b1;
      else if (flag_clear_done)
        done_flag_reg <= 1'b0;
      if ((state_reg == ST_OUT) && short_packet_end)
        eot_flag_reg <= 1'b1;
      else if (flag_clear_eot)
        eot_flag_reg <= 1'b0;
      done_pulse_reg <= (state_reg != ST_IDLE) && hit_zero;
    end
  end

  // Reads show the live counter, so software sees the bytes still left.
  always @*
  begin
    case (reg_addr)
      `GDSC_CNT_B0_ADDR: rd_mux = remaining_byte_count_reg[7:0];
      `GDSC_CNT_B1_ADDR: rd_mux = remaining_byte_count_reg[15:8];
      `GDSC_CNT_B2_ADDR: rd_mux = remaining_byte_count_reg[23:16];
      `GDSC_CNT_B3_ADDR: rd_mux = remaining_byte_count_reg[31:24];
      `GDSC_CFG_LO_ADDR: rd_mux = cfg_reg[7:0];
      `GDSC_CFG_HI_ADDR: rd_mux = cfg_reg[15:8];
      default:           rd_mux = 8'h00;
    endcase
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= reg_rd;
      if (reg_rd)
        rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata             = rdata_reg;
  assign reg_rvalid            = rvalid_reg;
  assign xfer_active           = (state_reg != ST_IDLE);
  assign transfer_done_flag    = done_flag_reg;
  assign transfer_done_pulse   = done_pulse_reg;
  assign short_packet_end_flag = eot_flag_reg;

endmodule

// ==== tb/gdsc_monitor.sv ====
/*
  Port checker of the slave DMA counter and configuration block.
  Assumes it is bound to gdsc_core and sees only that module's ports.
*/
`timescale 1ns/100ps
module gdsc_monitor
(
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Register port
  input wire reg_rd,
  input wire reg_rvalid,
  // DMA bus
  input wire dma_request_pin,
  input wire dma_request_oe,
  input wire write_strobe_pin,
  input wire dma_data_oe,
  // Endpoint side and status
  input wire ep_in_valid,
  input wire ep_in_ready,
  input wire ep_out_release,
  input wire xfer_active,
  input wire transfer_done_flag,
  input wire transfer_done_pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  oe_after_reset_a: assert property ($fell(sys_rst) |-> !dma_request_oe)
    else $error("request enable high straight after reset");
  req_needs_oe_a: assert property (dma_request_pin |-> dma_request_oe)
    else $error("request raised before configuration write");
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  done_single_a: assert property (transfer_done_pulse |=> !transfer_done_pulse)
    else $error("done pulse longer than one cycle");
  done_with_flag_a: assert property (transfer_done_pulse |-> transfer_done_flag)
    else $error("done pulse without done flag");
  done_ends_xfer_a: assert property ($rose(transfer_done_pulse) |-> !xfer_active)
    else $error("transfer still active at done");
  out_release_a: assert property (ep_out_release |-> !xfer_active)
    else $error("out buffer released during transfer");
  bus_drive_a: assert property (dma_data_oe |-> xfer_active)
    else $error("data bus driven while idle");
  in_drain_a: assert property ((ep_in_ready && !write_strobe_pin) [*6] |-> !ep_in_valid)
    else $error("in data left in fifo too long");
  cover property (transfer_done_pulse);
  cover property (ep_out_release);
  cover property (dma_data_oe && xfer_active);
endmodule

// ==== tb/gdsc_dma_ctrl.sv ====
/*
  Behavioural external DMA controller on the slave DMA bus.
  Assumes the device samples strobes and data on the rising clock edge.
*/
`timescale 1ns/100ps
module gdsc_dma_ctrl
(
  // Clock and bench control
  input  wire        clock,
  input  wire        run_in,
  input  wire        run_out,
  input  wire        slow,
  // Device DMA bus
  input  wire        dma_request_pin,
  input  wire [15:0] dma_data_out,
  output reg         write_strobe_pin,
  output reg         read_strobe_pin,
  output reg  [15:0] dma_data_in,
  // Traffic seen
  output reg  [15:0] last_read,
  output reg  [15:0] n_wr,
  output reg  [15:0] n_rd
);
  reg        gap;
  wire [7:0] nxt;
  assign nxt = n_wr[7:0] + {7'h00, write_strobe_pin};
  initial
  begin
    {gap, write_strobe_pin, read_strobe_pin} = 3'h0;
    {dma_data_in, last_read, n_wr, n_rd} = 64'h0;
  end
  // A released data bus flips to its own inverse every cycle, so stale data never passes.
  always @(negedge clock)
  begin
    if (write_strobe_pin)
      n_wr <= n_wr + 16'h0001;
    if (read_strobe_pin)
      n_rd <= n_rd + 16'h0001;
    if (read_strobe_pin)
      last_read <= dma_data_out;
    gap <= slow & ~gap;
    write_strobe_pin <= run_in & dma_request_pin & ~gap;
    read_strobe_pin <= run_out & dma_request_pin & ~gap;
    if (run_in & dma_request_pin & ~gap)
      dma_data_in <= {8'hb0 + nxt, 8'ha0 + nxt};
    else
      dma_data_in <= ~dma_data_in;
  end
endmodule

// ==== tb/testbench.sv ====
/*
  Self-checking bench of the slave DMA counter and configuration block.
  Assumes gdsc_core, its checker and the DMA controller model are compiled.
*/
`timescale 1ns/100ps
module testbench;
  logic        clock, sys_rst, reg_wr, reg_rd, run_in, run_out, slow;
  logic        ep_in_ready, ep_out_valid;
  logic [7:0]  reg_addr, reg_wdata, acc, out_words, n_in, last_in;
  logic [6:0]  cmd;
  logic [15:0] nb;
  wire  [7:0]  reg_rdata;
  wire  [1:0]  ep_in_count;
  wire  [15:0] dma_data_in, dma_data_out, ep_in_data, last_read, n_wr, n_rd;
  wire         reg_rvalid, dma_request_pin, dma_request_oe, write_strobe_pin;
  wire         read_strobe_pin, dma_data_oe, ep_in_valid, ep_out_ready, ep_out_release;
  wire         xfer_active, transfer_done_flag, transfer_done_pulse, short_packet_end_flag;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          i;
  gdsc_core dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .cmd_in_start(cmd[0]), .cmd_out_start(cmd[1]),
    .cmd_stop(cmd[2]), .cmd_dma_reset(cmd[3]), .short_packet_end(cmd[4]),
    .dma_request_pin(dma_request_pin), .dma_request_oe(dma_request_oe),
    .write_strobe_pin(write_strobe_pin), .read_strobe_pin(read_strobe_pin),
    .dma_data_in(dma_data_in), .dma_data_out(dma_data_out), .dma_data_oe(dma_data_oe),
    .ep_in_valid(ep_in_valid), .ep_in_count(ep_in_count), .ep_in_data(ep_in_data),
    .ep_in_ready(ep_in_ready), .ep_out_valid(ep_out_valid), .ep_out_count(2'h2),
    .ep_out_data({8'h11, acc}), .ep_out_ready(ep_out_ready),
    .ep_out_release(ep_out_release), .xfer_active(xfer_active),
    .transfer_done_flag(transfer_done_flag), .transfer_done_pulse(transfer_done_pulse),
    .short_packet_end_flag(short_packet_end_flag), .flag_clear_done(cmd[5]),
    .flag_clear_eot(cmd[6]));
  gdsc_dma_ctrl host (.clock(clock), .run_in(run_in), .run_out(run_out), .slow(slow),
    .dma_request_pin(dma_request_pin), .dma_data_out(dma_data_out),
    .write_strobe_pin(write_strobe_pin), .read_strobe_pin(read_strobe_pin),
    .dma_data_in(dma_data_in), .last_read(last_read), .n_wr(n_wr), .n_rd(n_rd));
  task close_out;
  begin
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
  begin
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk(reg_rvalid, 1);
    chk(reg_rdata, e);
  end
  endtask
  // Counter bytes go lowest first; only the top byte loads the counter.
  task ctr(input logic [31:0] v);
    int k;
  begin
    for (k = 0; k < 4; k++)
      wr(8'h34 + k[7:0], v[8 * k +: 8]);
  end
  endtask
  task go(input logic [6:0] c);
  begin
    @(negedge clock);
    cmd = c;
    @(negedge clock);
    cmd = 7'h00;
  end
  endtask
  task idle;
    int k;
  begin
    for (k = 0; k < 300 && xfer_active === 1'b1; k++)
      @(negedge clock);
    // One more edge lets the partner model book its last strobe.
    @(negedge clock);
    chk(xfer_active, 0);
  end
  endtask
  always @(posedge clock)
  begin
    if (ep_in_valid && ep_in_ready)
      n_in <= n_in + {6'h00, ep_in_count};
    if (ep_in_valid && ep_in_ready)
      last_in <= (ep_in_count == 2'h2) ? ep_in_data[15:8] : ep_in_data[7:0];
    if (ep_out_valid && ep_out_ready)
      acc <= acc + 8'h01;
  end
  always @(negedge clock)
    ep_out_valid <= acc < out_words;
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    close_out;
  end
  initial
  begin
    {sys_rst, reg_wr, reg_rd, run_in, run_out, slow, ep_out_valid} = 7'h40;
    {reg_addr, reg_wdata, cmd, acc, out_words, n_in, last_in} = '0;
    ep_in_ready = 1'b1;
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    for (i = 0; i < 6; i++) rd(8'h34 + i[7:0], (i == 4) ? 8'h01 : 8'h00);
    rd(8'h3a, 8'h00);
    chk(dma_request_oe, 0);
    for (i = 0; i < 3; i++) wr(8'h34 + i[7:0], 8'h01 + i[7:0]);
    rd(8'h34, 8'h00);
    wr(8'h37, 8'h04);
    for (i = 0; i < 4; i++) rd(8'h34 + i[7:0], 8'h01 + i[7:0]);
    wr(8'h38, 8'hff);
    rd(8'h38, 8'h8d);
    chk(dma_request_oe, 1);
    go(7'h01);
    chk(dma_request_pin, 0);
    go(7'h04);
    wr(8'h38, 8'h00);
    ctr(32'h5);
    nb = n_wr;
    run_in <= 1'b1;
    go(7'h01);
    idle;
    chk(n_wr - nb, 5);
    rd(8'h34, 8'h00);
    chk(transfer_done_flag, 1);
    chk(n_in, 5);
    chk(last_in, 8'ha4);
    go(7'h20);
    chk(transfer_done_flag, 0);
    wr(8'h38, 8'h01);
    ctr(32'h3);
    nb = n_wr;
    go(7'h01);
    idle;
    chk(n_wr - nb, 2);
    rd(8'h34, 8'h00);
    chk(transfer_done_flag, 1);
    go(7'h20);
    wr(8'h38, 8'h81);
    ctr(32'h4);
    ep_in_ready <= 1'b0;
    go(7'h01);
    repeat (20) @(negedge clock);
    ep_in_ready <= 1'b1;
    go(7'h04);
    chk(xfer_active, 0);
    rd(8'h34, 8'h04);
    chk(transfer_done_flag, 0);
    run_in <= 1'b0;
    wr(8'h38, 8'h01);
    ctr(32'h4);
    nb = n_rd;
    {slow, out_words, run_out} <= {1'b1, 8'h02, 1'b1};
    go(7'h02);
    idle;
    repeat (2) @(negedge clock);
    chk(n_rd - nb, 2);
    chk(last_read, 16'h1101);
    chk(ep_out_release, 1);
    chk(transfer_done_flag, 1);
    ctr(32'h8);
    out_words <= 8'h06;
    go(7'h02);
    repeat (4) @(negedge clock);
    go(7'h10);
    chk(xfer_active, 0);
    chk(short_packet_end_flag, 1);
    go(7'h40);
    chk(short_packet_end_flag, 0);
    go(7'h08);
    rd(8'h38, 8'h01);
    chk(dma_request_oe, 0);
    run_out <= 1'b0;
    close_out;
  end
endmodule
bind gdsc_core gdsc_monitor mon (.clock(clock), .sys_rst(sys_rst), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .dma_request_pin(dma_request_pin),
  .dma_request_oe(dma_request_oe), .write_strobe_pin(write_strobe_pin),
  .dma_data_oe(dma_data_oe), .ep_in_valid(ep_in_valid), .ep_in_ready(ep_in_ready),
  .ep_out_release(ep_out_release), .xfer_active(xfer_active),
  .transfer_done_flag(transfer_done_flag), .transfer_done_pulse(transfer_done_pulse));
